// file: smp_cfg.svh
// constants for the serial memory pin sharing and strap block
`ifndef SMP_CFG_SVH
`define SMP_CFG_SVH

// ****************************************
// widths
// ****************************************
`define SMP_MODE_W      2
`define SMP_SYNC_W      6

// ****************************************
// synchroniser bit positions
// ****************************************
`define SMP_SB_DATA     0
`define SMP_SB_LCLK     1
`define SMP_SB_TXEN     2
`define SMP_SB_RXDV     3
`define SMP_SB_AUTO     4
`define SMP_SB_REV      5

// ****************************************
// reset values
// ****************************************
`define SMP_LOW         1'b0
`define SMP_HIGH        1'b1
`define SMP_SYNC_RST    6'h00

`endif

// file: smp_pkg.sv
// types for the serial memory pin sharing and strap block
`include "smp_cfg.svh"

package smp_pkg;

   // role of a shared pin
   typedef enum logic [`SMP_MODE_W-1:0]
   {
      SMP_MODE_MEM   = 2'b00,
      SMP_MODE_AUX   = 2'b01,
      SMP_MODE_MON_A = 2'b10,
      SMP_MODE_MON_B = 2'b11
   } smp_mode_e;

endpackage

// file: smp_sync2.sv
// two-flop synchroniser for a vector of unrelated levels
`timescale 1ns/1ps
`include "smp_cfg.svh"

module smp_sync2
   import smp_pkg::*;
#(
   parameter int W = `SMP_SYNC_W
)
(
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // levels in and out
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta_r <= W'(`SMP_SYNC_RST);
         q_o    <= W'(`SMP_SYNC_RST);
      end
      else
      begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end

endmodule // smp_sync2

// file: smp_pin_sel.sv
// role selector for one shared output pin
`timescale 1ns/1ps
`include "smp_cfg.svh"

module smp_pin_sel
   import smp_pkg::*;
(
   // selected role
   input  wire smp_mode_e mode_i,
   // candidate values
   input  wire logic      mem_i,
   input  wire logic      aux_i,
   input  wire logic      mon_a_i,
   input  wire logic      mon_b_i,
   // chosen value and memory role flag
   output logic           val_o,
   output logic           is_mem_o
);

   // output-only roles, no input path here
   always_comb
   begin
      is_mem_o = (mode_i == SMP_MODE_MEM);
      case (mode_i)
         SMP_MODE_MEM:   val_o = mem_i;
         SMP_MODE_AUX:   val_o = aux_i;
         SMP_MODE_MON_A: val_o = mon_a_i;
         SMP_MODE_MON_B: val_o = mon_b_i;
         default:        val_o = mem_i;
      endcase
   end

endmodule // smp_pin_sel

// file: smp_pin_mux.sv
// top: shared serial memory pins, bus width strap, pair swap
`timescale 1ns/1ps
`include "smp_cfg.svh"

module smp_pin_mux
   import smp_pkg::*;
(
   // core clock and reset
   input  wire logic                  CLOCK_I,
   input  wire logic                  RST_I,
   // link clock and internal mii levels
   input  wire logic                  LINK_CLK_I,
   input  wire logic                  MII_TX_EN_I,
   input  wire logic                  MII_RX_DV_I,
   // pin role configuration
   input  wire logic [`SMP_MODE_W-1:0] DATA_PIN_MODE_I,
   input  wire logic [`SMP_MODE_W-1:0] CLOCK_PIN_MODE_I,
   input  wire logic                  AUX_OUTPUT_THREE_I,
   input  wire logic                  AUX_OUTPUT_FOUR_I,
   // memory access engine side
   input  wire logic                  MEM_SELECT_REQ_I,
   input  wire logic                  MEM_CLOCK_I,
   input  wire logic                  MEM_DATA_OUT_I,
   input  wire logic                  MEM_DATA_DRIVE_I,
   output logic                       MEM_DATA_IN_O,
   // shared pins
   input  wire logic                  SERIAL_MEM_DATA_PIN_I,
   output logic                       SERIAL_MEM_DATA_PIN_O,
   output logic                       SERIAL_MEM_DATA_PIN_OE_N_O,
   output logic                       SERIAL_MEM_CLOCK_O,
   output logic                       SERIAL_MEM_SELECT_O,
   // bus width strap result
   output logic                       BUS_WIDTH_32_O,
   output logic                       BUS_WIDTH_VALID_O,
   // crossover control
   input  wire logic                  CROSSOVER_AUTO_ENABLE_I,
   input  wire logic                  REVERSE_DETECTED_I,
   input  wire logic                  CROSSOVER_MANUAL_I,
   output logic                       CROSSOVER_AUTO_ACTIVE_O,
   output logic                       CROSSOVER_SWAP_O
);

   // ****************************************
   // link clock domain
   // ****************************************

   logic tx_en_link_r;
   logic rx_dv_link_r;

   // mii levels retimed on their own clock
   always_ff @(posedge LINK_CLK_I)
   begin
      tx_en_link_r <= MII_TX_EN_I;
      rx_dv_link_r <= MII_RX_DV_I;
   end

   // ****************************************
   // crossings into the core domain
   // ****************************************

   logic [`SMP_SYNC_W-1:0] async_in;
   logic [`SMP_SYNC_W-1:0] sync_q;

   // every foreign level gets two flops
   // link clock itself is taken as a level for the clock monitors
   always_comb
   begin
      async_in                = '0;
      async_in[`SMP_SB_DATA]  = SERIAL_MEM_DATA_PIN_I;
      async_in[`SMP_SB_LCLK]  = LINK_CLK_I;
      async_in[`SMP_SB_TXEN]  = tx_en_link_r;
      async_in[`SMP_SB_RXDV]  = rx_dv_link_r;
      async_in[`SMP_SB_AUTO]  = CROSSOVER_AUTO_ENABLE_I;
      async_in[`SMP_SB_REV]   = REVERSE_DETECTED_I;
   end

   smp_sync2 #(
      .W (`SMP_SYNC_W)
   ) u_sync (
      .clk_i (CLOCK_I),
      .rst_i (RST_I),
      .d_i   (async_in),
      .q_o   (sync_q)
   );

   // ****************************************
   // pin role selection
   // ****************************************

   smp_mode_e data_mode;
   smp_mode_e clock_mode;
   logic      data_val;
   logic      data_is_mem;
   logic      clock_val;
   logic      clock_is_mem;

   assign data_mode  = smp_mode_e'(DATA_PIN_MODE_I);
   assign clock_mode = smp_mode_e'(CLOCK_PIN_MODE_I);

   smp_pin_sel u_data_sel (
      .mode_i   (data_mode),
      .mem_i    (MEM_DATA_OUT_I),
      .aux_i    (AUX_OUTPUT_THREE_I),
      .mon_a_i  (sync_q[`SMP_SB_TXEN]),
      .mon_b_i  (sync_q[`SMP_SB_LCLK]),
      .val_o    (data_val),
      .is_mem_o (data_is_mem)
   );

   smp_pin_sel u_clock_sel (
      .mode_i   (clock_mode),
      .mem_i    (MEM_CLOCK_I),
      .aux_i    (AUX_OUTPUT_FOUR_I),
      .mon_a_i  (sync_q[`SMP_SB_RXDV]),
      .mon_b_i  (sync_q[`SMP_SB_LCLK]),
      .val_o    (clock_val),
      .is_mem_o (clock_is_mem)
   );

   // ****************************************
   // bus width strap capture
   // ****************************************

   // release edge E0: synchroniser takes the pin, E0+1 its output, E0+2 caught
   // the synchroniser is cleared by reset, so its output is not the pin before E0+1
   logic in_reset_r;
   logic strap_wait_r;
   logic strap_take_r;

   // remembers that reset was seen, so the release is found
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         in_reset_r <= `SMP_HIGH;
      end
      else
      begin
         in_reset_r <= `SMP_LOW;
      end
   end

   // waits out the synchroniser after release
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         strap_wait_r <= `SMP_LOW;
      end
      else
      begin
         strap_wait_r <= in_reset_r;
      end
   end

   // second wait, until the pin level seen at release leaves the synchroniser
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         strap_take_r <= `SMP_LOW;
      end
      else
      begin
         strap_take_r <= strap_wait_r;
      end
   end

   // catch the pin level once after release
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         BUS_WIDTH_32_O    <= `SMP_LOW;
         BUS_WIDTH_VALID_O <= `SMP_LOW;
      end
      // pin stays released meanwhile, so only the strap resistor sets it
      else if (strap_take_r && !BUS_WIDTH_VALID_O)
      begin
         // high gives 32-bit, low gives 16-bit
         BUS_WIDTH_32_O    <= sync_q[`SMP_SB_DATA];
         BUS_WIDTH_VALID_O <= `SMP_HIGH;
      end
   end

   // ****************************************
   // shared pin drivers
   // ****************************************

   // data pin value and enable; released until strap is caught
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         SERIAL_MEM_DATA_PIN_O      <= `SMP_LOW;
         SERIAL_MEM_DATA_PIN_OE_N_O <= `SMP_HIGH;
      end
      else
      begin
         SERIAL_MEM_DATA_PIN_O <= data_val;
         if (!BUS_WIDTH_VALID_O)
         begin
            SERIAL_MEM_DATA_PIN_OE_N_O <= `SMP_HIGH; // keep strap readable
         end
         else if (data_is_mem)
         begin
            SERIAL_MEM_DATA_PIN_OE_N_O <= !MEM_DATA_DRIVE_I;
         end
         else
         begin
            SERIAL_MEM_DATA_PIN_OE_N_O <= `SMP_LOW;
         end
      end
   end

   // received memory data back to the engine
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         MEM_DATA_IN_O <= `SMP_LOW;
      end
      else
      begin
         MEM_DATA_IN_O <= data_is_mem ? sync_q[`SMP_SB_DATA] : `SMP_LOW;
      end
   end

   // clock pin is always an output
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         SERIAL_MEM_CLOCK_O <= `SMP_LOW;
      end
      else
      begin
         SERIAL_MEM_CLOCK_O <= clock_val;
      end
   end

   // memory select only while both pins serve the memory
   // deselect wins over any engine request
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         SERIAL_MEM_SELECT_O <= `SMP_LOW;
      end
      else if (!data_is_mem)
      begin
         SERIAL_MEM_SELECT_O <= `SMP_LOW;
      end
      else if (!clock_is_mem)
      begin
         SERIAL_MEM_SELECT_O <= `SMP_LOW;
      end
      else
      begin
         SERIAL_MEM_SELECT_O <= MEM_SELECT_REQ_I;
      end
   end

   // ****************************************
   // twisted pair crossover
   // ****************************************

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         CROSSOVER_AUTO_ACTIVE_O <= `SMP_LOW;
      end
      else
      begin
         CROSSOVER_AUTO_ACTIVE_O <= sync_q[`SMP_SB_AUTO];
      end
   end

   // swap pairs on manual reversal, or on detected reversal while auto crossover is enabled
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         CROSSOVER_SWAP_O <= `SMP_LOW;
      end
      else
      begin
         CROSSOVER_SWAP_O <= CROSSOVER_MANUAL_I ||
                             (sync_q[`SMP_SB_AUTO] && sync_q[`SMP_SB_REV]);
      end
   end

endmodule // smp_pin_mux

// file: smp_pin_mux_properties.sv
// checker for the shared serial memory pin block
`timescale 1ns/1ps
`include "smp_cfg.svh"
module smp_pin_mux_chk
(
   // clock and reset
   input wire logic                   CLOCK_I,
   input wire logic                   RST_I,
   // configuration and engine
   input wire logic [`SMP_MODE_W-1:0] DATA_PIN_MODE_I,
   input wire logic [`SMP_MODE_W-1:0] CLOCK_PIN_MODE_I,
   input wire logic                   AUX_OUTPUT_THREE_I,
   input wire logic                   MEM_SELECT_REQ_I,
   input wire logic                   MEM_CLOCK_I,
   input wire logic                   CROSSOVER_AUTO_ENABLE_I,
   input wire logic                   CROSSOVER_MANUAL_I,
   // pins and results
   input wire logic                   SERIAL_MEM_DATA_PIN_I,
   input wire logic                   SERIAL_MEM_DATA_PIN_O,
   input wire logic                   SERIAL_MEM_DATA_PIN_OE_N_O,
   input wire logic                   SERIAL_MEM_CLOCK_O,
   input wire logic                   SERIAL_MEM_SELECT_O,
   input wire logic                   BUS_WIDTH_32_O,
   input wire logic                   BUS_WIDTH_VALID_O,
   input wire logic                   CROSSOVER_AUTO_ACTIVE_O,
   input wire logic                   CROSSOVER_SWAP_O
);
   // ****************************************
   // core domain properties
   // ****************************************
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RST_I);

   select_forced_a: assert property ((DATA_PIN_MODE_I != 2'h0 || CLOCK_PIN_MODE_I != 2'h0)
      |=> !SERIAL_MEM_SELECT_O) else $error("select active while a pin is repurposed");
   select_follow_a: assert property ((DATA_PIN_MODE_I == 2'h0 && CLOCK_PIN_MODE_I == 2'h0)
      && BUS_WIDTH_VALID_O && MEM_SELECT_REQ_I |=> SERIAL_MEM_SELECT_O) else $error("select lost");
   aux_three_a: assert property (BUS_WIDTH_VALID_O && DATA_PIN_MODE_I == 2'h1 |=>
      !SERIAL_MEM_DATA_PIN_OE_N_O && SERIAL_MEM_DATA_PIN_O == $past(AUX_OUTPUT_THREE_I))
      else $error("aux output three wrong");
   mem_clock_a: assert property (CLOCK_PIN_MODE_I == 2'h0 |=>
      SERIAL_MEM_CLOCK_O == $past(MEM_CLOCK_I)) else $error("memory clock wrong");
   width_hold_a: assert property (BUS_WIDTH_VALID_O |=> BUS_WIDTH_VALID_O
      && $stable(BUS_WIDTH_32_O)) else $error("bus width changed");
   strap_catch_a: assert property ($fell(RST_I) |-> !BUS_WIDTH_VALID_O ##3
      (BUS_WIDTH_VALID_O && BUS_WIDTH_32_O == $past(SERIAL_MEM_DATA_PIN_I, 3)))
      else $error("strap not caught");
   manual_swap_a: assert property (CROSSOVER_MANUAL_I |=> CROSSOVER_SWAP_O)
      else $error("manual swap missing");
   auto_follow_a: assert property (CROSSOVER_AUTO_ENABLE_I [*4] |=> CROSSOVER_AUTO_ACTIVE_O)
      else $error("auto crossover not enabled");

   // main scenarios seen
   cover property ($rose(BUS_WIDTH_VALID_O) && BUS_WIDTH_32_O);
   cover property (CROSSOVER_SWAP_O && !CROSSOVER_MANUAL_I);
   cover property (DATA_PIN_MODE_I == 2'h1 && !SERIAL_MEM_DATA_PIN_OE_N_O);
endmodule // smp_pin_mux_chk

bind smp_pin_mux smp_pin_mux_chk smp_pin_mux_chk_i (.CLOCK_I, .RST_I, .DATA_PIN_MODE_I,
   .CLOCK_PIN_MODE_I, .AUX_OUTPUT_THREE_I, .MEM_SELECT_REQ_I, .MEM_CLOCK_I,
   .CROSSOVER_AUTO_ENABLE_I, .CROSSOVER_MANUAL_I, .SERIAL_MEM_DATA_PIN_I,
   .SERIAL_MEM_DATA_PIN_O, .SERIAL_MEM_DATA_PIN_OE_N_O, .SERIAL_MEM_CLOCK_O,
   .SERIAL_MEM_SELECT_O, .BUS_WIDTH_32_O, .BUS_WIDTH_VALID_O,
   .CROSSOVER_AUTO_ACTIVE_O, .CROSSOVER_SWAP_O);

// file: smp_mem_model.sv
// behavioural serial memory with the bus width strap resistor
`timescale 1ns/1ps
module smp_mem_model
(
   // pins seen by the memory
   input  wire logic sel_i,
   input  wire logic sclk_i,
   input  wire logic pin_o_i,
   input  wire logic oe_n_i,
   input  wire logic strap_i,
   // resolved data line
   output logic      pad_o
);
   logic [7:0] pat_r = 8'hA5;

   // memory shifts out
   // next bit on each memory clock rise while answering
   always @(posedge sclk_i)
      if (sel_i && oe_n_i)
         pat_r <= {pat_r[6:0], pat_r[7]};

   // strap resistor level
   // device drive wins, else memory, else pull level
   assign pad_o = !oe_n_i ? pin_o_i : (sel_i ? pat_r[7] : strap_i);
endmodule // smp_mem_model

// file: tb.sv
// bench for the shared serial memory pin block
`timescale 1ns/1ps
module tb;
   logic CLOCK_I = 1'h0, RST_I = 1'h1, LINK_CLK_I = 1'h0, MII_TX_EN_I = 1'h0, MII_RX_DV_I = 1'h0;
   logic [1:0] DATA_PIN_MODE_I = 2'h0, CLOCK_PIN_MODE_I = 2'h0;
   logic AUX_OUTPUT_THREE_I = 1'h0, AUX_OUTPUT_FOUR_I = 1'h0, MEM_SELECT_REQ_I = 1'h0;
   logic MEM_CLOCK_I = 1'h0, MEM_DATA_OUT_I = 1'h0, MEM_DATA_DRIVE_I = 1'h0, strap = 1'h1;
   logic CROSSOVER_AUTO_ENABLE_I = 1'h0, REVERSE_DETECTED_I = 1'h0, CROSSOVER_MANUAL_I = 1'h0;
   logic MEM_DATA_IN_O, SERIAL_MEM_DATA_PIN_I, SERIAL_MEM_DATA_PIN_O, SERIAL_MEM_DATA_PIN_OE_N_O;
   logic SERIAL_MEM_CLOCK_O, SERIAL_MEM_SELECT_O, BUS_WIDTH_32_O, BUS_WIDTH_VALID_O;
   logic CROSSOVER_AUTO_ACTIVE_O, CROSSOVER_SWAP_O;
   logic [7:0]  ep;
   int          n_errors = 0, samples_checked = 0, tg, tk;
   // rows: data mode, clock mode, aux3, aux4, req, mclk, dout, drive | pin, oe_n, clk, sel
   logic [13:0] rows [7] = '{14'h00B9, 14'h00D3, 14'h12CA, 14'h1080, 14'h0592, 14'h04B8, 14'h2888};

   // clocks, link clock at its own phase
   always #2.5 CLOCK_I = ~CLOCK_I;
   initial
   begin
      #1.7;
      forever #40 LINK_CLK_I = ~LINK_CLK_I;
   end

   smp_pin_mux smp_pin_mux_i (.CLOCK_I, .RST_I, .LINK_CLK_I, .MII_TX_EN_I, .MII_RX_DV_I,
      .DATA_PIN_MODE_I, .CLOCK_PIN_MODE_I, .AUX_OUTPUT_THREE_I, .AUX_OUTPUT_FOUR_I,
      .MEM_SELECT_REQ_I, .MEM_CLOCK_I, .MEM_DATA_OUT_I, .MEM_DATA_DRIVE_I, .MEM_DATA_IN_O,
      .SERIAL_MEM_DATA_PIN_I, .SERIAL_MEM_DATA_PIN_O, .SERIAL_MEM_DATA_PIN_OE_N_O,
      .SERIAL_MEM_CLOCK_O, .SERIAL_MEM_SELECT_O, .BUS_WIDTH_32_O, .BUS_WIDTH_VALID_O,
      .CROSSOVER_AUTO_ENABLE_I, .REVERSE_DETECTED_I, .CROSSOVER_MANUAL_I,
      .CROSSOVER_AUTO_ACTIVE_O, .CROSSOVER_SWAP_O);
   smp_mem_model smp_mem_model_i (.sel_i(SERIAL_MEM_SELECT_O), .sclk_i(SERIAL_MEM_CLOCK_O),
      .pin_o_i(SERIAL_MEM_DATA_PIN_O), .oe_n_i(SERIAL_MEM_DATA_PIN_OE_N_O), .strap_i(strap),
      .pad_o(SERIAL_MEM_DATA_PIN_I));

   task automatic tick(input int n);
      repeat (n) @(posedge CLOCK_I);
   endtask

   task automatic chk(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask

   // reset with a strap level, then check the caught width
   task automatic rst(input logic s);
      @(posedge CLOCK_I);
      RST_I <= 1'h1;
      strap <= s;
      tick(1);
      RST_I <= 1'h0;
      tick(2);
      chk("held_off", 1'h1, SERIAL_MEM_DATA_PIN_OE_N_O);
      chk("not_yet", 1'h0, BUS_WIDTH_VALID_O);
      tick(2);
      chk("valid", 1'h1, BUS_WIDTH_VALID_O);
      chk("width32", s, BUS_WIDTH_32_O);
      $display("test reset strap %b done", s);
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // watchdog against a hang
   initial
   begin
      #20000;
      n_errors++;
      report_and_stop();
   end

   initial
   begin
      rst(1'h1);
      strap <= 1'h0;
      tick(8);
      chk("width_kept", 1'h1, BUS_WIDTH_32_O);
      MII_TX_EN_I <= 1'h1;
      // table of pin roles
      foreach (rows[i])
      begin
         @(posedge CLOCK_I);
         {DATA_PIN_MODE_I, CLOCK_PIN_MODE_I, AUX_OUTPUT_THREE_I, AUX_OUTPUT_FOUR_I, MEM_SELECT_REQ_I,
            MEM_CLOCK_I, MEM_DATA_OUT_I, MEM_DATA_DRIVE_I} <= rows[i][13:4];
         tick(40);
         chk("data_pin", rows[i][3], SERIAL_MEM_DATA_PIN_O);
         chk("oe_n", rows[i][2], SERIAL_MEM_DATA_PIN_OE_N_O);
         chk("clock_pin", rows[i][1], SERIAL_MEM_CLOCK_O);
         chk("select", rows[i][0], SERIAL_MEM_SELECT_O);
      end
      $display("test pin roles done");
      // memory read: pin released, memory answers
      {DATA_PIN_MODE_I, CLOCK_PIN_MODE_I, MEM_DATA_DRIVE_I} <= 5'h00;
      tick(8);
      ep = 8'hA5;
      for (int k = 0; k < 4; k++)
      begin
         chk("mem_in", ep[7], MEM_DATA_IN_O);
         chk("released", 1'h1, SERIAL_MEM_DATA_PIN_OE_N_O);
         MEM_CLOCK_I <= 1'h1;
         tick(8);
         MEM_CLOCK_I <= 1'h0;
         tick(8);
         ep = {ep[6:0], ep[7]};
      end
      {DATA_PIN_MODE_I, AUX_OUTPUT_THREE_I} <= 3'h3;
      tick(6);
      chk("no_input", 1'h0, MEM_DATA_IN_O);
      $display("test memory read done");
      // level monitors
      {DATA_PIN_MODE_I, CLOCK_PIN_MODE_I, MII_TX_EN_I, MII_RX_DV_I} <= 6'h29;
      tick(40);
      chk("tx_en_mon", 1'h0, SERIAL_MEM_DATA_PIN_O);
      chk("rx_dv_mon", 1'h1, SERIAL_MEM_CLOCK_O);
      // link clock monitors: 320 ns spans eight link edges
      {DATA_PIN_MODE_I, CLOCK_PIN_MODE_I} <= 4'hF;
      tick(10);
      tg = 0;
      tk = 0;
      repeat (64)
      begin
         ep[0] = SERIAL_MEM_DATA_PIN_O;
         ep[1] = SERIAL_MEM_CLOCK_O;
         @(posedge CLOCK_I);
         #1;
         tg += (ep[0] !== SERIAL_MEM_DATA_PIN_O);
         tk += (ep[1] !== SERIAL_MEM_CLOCK_O);
      end
      chk("tx_clk_mon", 1'h1, tg inside {[7:9]});
      chk("rx_clk_mon", 1'h1, tk inside {[7:9]});
      chk("select_mon", 1'h0, SERIAL_MEM_SELECT_O);
      $display("test monitors done");
      // every crossover combination
      for (int k = 0; k < 8; k++)
      begin
         @(posedge CLOCK_I);
         {CROSSOVER_AUTO_ENABLE_I, REVERSE_DETECTED_I, CROSSOVER_MANUAL_I} <= k[2:0];
         tick(6);
         chk("auto_active", k[2], CROSSOVER_AUTO_ACTIVE_O);
         chk("swap", k[0] | (k[2] & k[1]), CROSSOVER_SWAP_O);
      end
      $display("test crossover done");
      // second reset in mid-run with a low strap
      {DATA_PIN_MODE_I, CLOCK_PIN_MODE_I, MEM_SELECT_REQ_I} <= 5'h00;
      rst(1'h0);
      report_and_stop();
   end
endmodule // tb
